/* jlf_pkg.sv */
// package for the 64b/66b link framer: block layout, sync stream layout,
// polynomials and reset values.
// assumes nothing beyond a systemverilog-2012 compiler.
package jlf_pkg;

   // =====================================================================
   // block structure
   // =====================================================================
   localparam int          BLK_PER_MB   = 32;   // blocks in one multiblock
   localparam int          PAYLOAD_W    = 64;   // eight octets
   localparam int          BLOCK_W      = 66;   // header pair plus payload
   localparam int          OCTETS       = 8;
   localparam int          HDR_LSB      = 0;    // header pair positions 0..1
   localparam int          PAYLOAD_LSB  = 2;    // octet k at 2+8k
   localparam logic [1:0]  HDR_ONE      = 2'h2; // pos0=0, pos1=1 conveys a one
   localparam logic [1:0]  HDR_ZERO     = 2'h1; // pos0=1, pos1=0 conveys a zero

   // =====================================================================
   // sync header stream layout
   // =====================================================================
   localparam int          EXTENDED_GROUP_END_FLAG_POS    = 22;
   localparam int          END_FIRST    = 27;   // 0,0,0,0,1 at 27..31
   localparam int          END_LAST     = 31;
   localparam logic [1:0]  MODE_CRC     = 2'h0;
   localparam logic [1:0]  MODE_FEC     = 2'h2;

   // =====================================================================
   // polynomials, state widths and reset values
   // =====================================================================
   localparam int          CRC_W        = 12;
   localparam logic [11:0] CRC_POLY     = 12'h987;
   localparam int          FEC_W        = 26;
   localparam logic [25:0] FEC_POLY     = 26'h0220211;
   localparam int          SCR_W        = 58;
   localparam logic [57:0] SCR_SEED     = 58'h3ffffffffffffff;
   localparam int          SCR_TAP_A    = 38;   // x^39 term
   localparam int          SCR_TAP_B    = 57;   // x^58 term
   localparam logic [25:0] PARITY_RST   = 26'h0000000;
   localparam logic [65:0] BLOCK_RST    = 66'h0;

endpackage

/* jlf_framer.sv */
// transmit link layer, 64b/66b: scrambles blocks, adds header pairs,
// counts multiblocks and extended multiblocks, builds the sync stream.
// assumes one payload word per mclk_in cycle from the transport layer,
// and a sysref_in pin that is asynchronous to mclk_in.
//
// Notes on behaviour
// - pack eight octets, scramble, prepend header pair
// - header at 0..1, octets ascending to 65
// - thirty-two blocks make one multiblock
// - e multiblocks form one extended multiblock
// - sysref resets extended group clock phase
// - header pair always complementary, 01 is one
// - header bits form 32-bit stream in order
// - stream ends 00001, unique in crc mode
// - bit 22 set only in last multiblock
// - only crc-12 and fec stream formats
// - crc of multiblock sent in next one
// - format select zero picks crc-12
// - crc stream: parity, ones, command, zeros
// - all seven command positions sent zero
// - crc polynomial 0x987
// - parity over 2048 payload bits, cleared each
// - format select two picks 26-bit fec
`timescale 1ns/1ps

module jlf_framer #(
   parameter int EMB_LEN = 1   // multiblocks per extended multiblock
) (
   // clock and reset
   input  wire logic        mclk_in,
   input  wire logic        nrst_in,
   // link control
   input  wire logic        link_en_in,
   input  wire logic [1:0]  sync_header_format_select_in,
   input  wire logic        sysref_in,
   // transport payload, octet k in bits 8k+7..8k
   input  wire logic [63:0] payload_in,
   // transmitted blocks
   output logic      [65:0] tx_block_out,
   output logic             tx_valid_out,
   // timing and status
   output logic             local_extended_group_clock_out,
   output logic             multiblock_end_marker_out,
   output logic             extended_group_end_flag_out,
   output logic             format_bad_out
);

   localparam int MBW = (EMB_LEN > 1) ? $clog2(EMB_LEN) : 1;
   localparam logic [MBW-1:0] MB_LAST = MBW'(EMB_LEN - 1);
   localparam logic [4:0]     BLK_LAST = 5'(jlf_pkg::BLK_PER_MB - 1);

   // =====================================================================
   // functions
   // =====================================================================
   // serial order: octet 0 first, msb of each octet first
   function automatic logic serial_bit(input logic [63:0] w, input int j);
      serial_bit = w[8 * (j / 8) + 7 - (j % 8)];
   endfunction

   // self-synchronous scrambler 1 + x^39 + x^58 over one block
   function automatic logic [121:0] scramble(input logic [63:0] d, input logic [57:0] st);
      logic [57:0] s;
      logic [63:0] o;
      logic        b;
      s = st;
      o = 64'h0;
      for (int j = 0; j < jlf_pkg::PAYLOAD_W; j++) begin
         b = serial_bit(d, j) ^ s[jlf_pkg::SCR_TAP_A] ^ s[jlf_pkg::SCR_TAP_B];
         o[8 * (j / 8) + 7 - (j % 8)] = b;
         s = {s[56:0], b};
      end
      scramble = {s, o};
   endfunction

   // one block through a parity divider of up to 26 bits
   function automatic logic [25:0] divide(input logic [63:0] w, input logic [25:0] acc,
                                          input logic [25:0] poly, input int width);
      logic [25:0] a;
      logic        fb;
      a = acc;
      for (int j = 0; j < jlf_pkg::PAYLOAD_W; j++) begin
         fb = serial_bit(w, j) ^ a[width - 1];
         a = {a[24:0], 1'b0};
         if (fb) begin
            a = a ^ poly;
         end
         a[25] = (width == jlf_pkg::FEC_W) ? a[25] : 1'b0;
         a[24:12] = (width == jlf_pkg::FEC_W) ? a[24:12] : 13'h0;
      end
      divide = a;
   endfunction

   // lay out one 32-bit sync header stream
   function automatic logic [31:0] build_stream(input logic [1:0] mode, input logic [25:0] p,
                                                input logic extended_group_end_flag);
      logic [31:0] s;
      s = 32'h0;
      if (mode == jlf_pkg::MODE_FEC) begin
         for (int i = 0; i < 22; i++) begin
            s[i] = p[25 - i];
         end
         s[23] = p[3];
         for (int k = 0; k < 3; k++) begin
            s[24 + k] = p[2 - k];
         end
      end else begin
         for (int g = 0; g < 4; g++) begin
            for (int k = 0; k < 3; k++) begin
               s[4 * g + k] = p[11 - 3 * g - k];
            end
            s[4 * g + 3] = 1'b1;
         end
         s[19] = 1'b1;
         s[21] = 1'b1;
         s[23] = 1'b1;                                       // command bits stay zero
      end
      s[jlf_pkg::EXTENDED_GROUP_END_FLAG_POS] = extended_group_end_flag;
      s[jlf_pkg::END_LAST] = 1'b1;                           // 27..30 already zero
      build_stream = s;
   endfunction

   // =====================================================================
   // sysref synchroniser
   // =====================================================================
   logic sr_meta_reg, sr_sync_reg, sr_last_reg;
   logic sr_edge;

   // first stage feeds only the second
   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         sr_meta_reg <= 1'b0;
         sr_sync_reg <= 1'b0;
         sr_last_reg <= 1'b0;
      end else begin
         sr_meta_reg <= sysref_in;
         sr_sync_reg <= sr_meta_reg;
         sr_last_reg <= sr_sync_reg;
      end
   end
   assign sr_edge = sr_sync_reg & ~sr_last_reg;

   // =====================================================================
   // framing state
   // =====================================================================
   logic [4:0]     blk_reg, blk_next;
   logic [MBW-1:0] mb_reg, mb_next;
   logic           active_reg, active_next;
   logic           first_mb_reg, first_mb_next;
   logic [1:0]     mode_reg, mode_next;
   logic [57:0]    scr_reg, scr_next;
   logic [25:0]    acc_reg, acc_next;
   logic [25:0]    parity_reg, parity_next;
   logic [65:0]    blk_out_reg, blk_out_next;
   logic           valid_reg, valid_next;
   logic           local_extended_group_clock_reg, local_extended_group_clock_next;
   logic           mbend_reg, mbend_next;
   logic           embend_reg, embend_next;
   logic           bad_reg, bad_next;
   logic [4:0]     oblk_reg, oblk_next;
   logic [MBW-1:0] omb_reg, omb_next;
   logic [1:0]     omode_reg, omode_next;
   logic [121:0]   scr_res;
   logic [31:0]    stream;
   logic [25:0]    acc_after;
   logic           last_blk;

   // next-state logic for counters, scrambler, parity and output block
   always_comb begin
      scr_res   = scramble(payload_in, scr_reg);
      acc_after = (mode_reg == jlf_pkg::MODE_FEC)
                ? divide(scr_res[63:0], acc_reg, jlf_pkg::FEC_POLY, jlf_pkg::FEC_W)
                // 0x987 keeps x^12 and drops the +1 term, so the xor mask is rebuilt from it
                : divide(scr_res[63:0], acc_reg, {14'h0, jlf_pkg::CRC_POLY[10:0], 1'b1}, jlf_pkg::CRC_W);
      stream    = build_stream(mode_reg, parity_reg, mb_reg == MB_LAST);
      last_blk  = (blk_reg == BLK_LAST);
      // block and multiblock counters, phase forced by sysref
      blk_next  = blk_reg + 5'h1;
      mb_next   = mb_reg;
      if (last_blk) begin
         mb_next = (mb_reg == MB_LAST) ? '0 : mb_reg + MBW'(1);
      end
      if (sr_edge) begin
         blk_next = 5'h0;
         mb_next  = '0;
      end
      // link starts when the next block is block 0, so no part multiblock goes out at start
      // format frozen while running
      active_next = link_en_in & (active_reg | last_blk) & ~sr_edge;
      mode_next   = active_reg ? mode_reg : sync_header_format_select_in;
      bad_next    = (mode_next != jlf_pkg::MODE_CRC) && (mode_next != jlf_pkg::MODE_FEC);
      // parity accumulator restarts each multiblock
      acc_next    = last_blk ? jlf_pkg::PARITY_RST : acc_after;
      parity_next = parity_reg;
      first_mb_next = first_mb_reg;
      if (active_reg && last_blk) begin
         parity_next   = acc_after;
         first_mb_next = 1'b0;
      end
      if (!active_reg) begin
         acc_next      = jlf_pkg::PARITY_RST;
         parity_next   = jlf_pkg::PARITY_RST;
         first_mb_next = 1'b1;
      end
      scr_next = active_reg ? scr_res[121:64] : jlf_pkg::SCR_SEED;
      // header pair then payload octets ascending
      blk_out_next = jlf_pkg::BLOCK_RST;
      if (active_reg) begin
         blk_out_next[jlf_pkg::HDR_LSB +: 2] = stream[blk_reg] ? jlf_pkg::HDR_ONE : jlf_pkg::HDR_ZERO;
         for (int k = 0; k < jlf_pkg::OCTETS; k++) begin
            blk_out_next[jlf_pkg::PAYLOAD_LSB + 8 * k +: 8] = scr_res[8 * k +: 8];
         end
      end
      valid_next  = active_reg;
      local_extended_group_clock_next   = (blk_reg == 5'h0) && (mb_reg == '0);
      mbend_next  = last_blk;
      embend_next = last_blk && (mb_reg == MB_LAST);
      oblk_next   = blk_reg;
      omb_next    = mb_reg;
      omode_next  = mode_reg;
   end

   // registers only
   always_ff @(posedge mclk_in) begin
      if (!nrst_in) begin
         blk_reg      <= 5'h0;
         mb_reg       <= '0;
         active_reg   <= 1'b0;
         first_mb_reg <= 1'b1;
         mode_reg     <= jlf_pkg::MODE_CRC;
         scr_reg      <= jlf_pkg::SCR_SEED;
         acc_reg      <= jlf_pkg::PARITY_RST;
         parity_reg   <= jlf_pkg::PARITY_RST;
         blk_out_reg  <= jlf_pkg::BLOCK_RST;
         valid_reg    <= 1'b0;
         local_extended_group_clock_reg     <= 1'b0;
         mbend_reg    <= 1'b0;
         embend_reg   <= 1'b0;
         bad_reg      <= 1'b0;
         oblk_reg     <= 5'h0;
         omb_reg      <= '0;
         omode_reg    <= jlf_pkg::MODE_CRC;
      end else begin
         blk_reg      <= blk_next;
         mb_reg       <= mb_next;
         active_reg   <= active_next;
         first_mb_reg <= first_mb_next;
         mode_reg     <= mode_next;
         scr_reg      <= scr_next;
         acc_reg      <= acc_next;
         parity_reg   <= parity_next;
         blk_out_reg  <= blk_out_next;
         valid_reg    <= valid_next;
         local_extended_group_clock_reg     <= local_extended_group_clock_next;
         mbend_reg    <= mbend_next;
         embend_reg   <= embend_next;
         bad_reg      <= bad_next;
         oblk_reg     <= oblk_next;
         omb_reg      <= omb_next;
         omode_reg    <= omode_next;
      end
   end

   // outputs straight from flops
   assign tx_block_out                   = blk_out_reg;
   assign tx_valid_out                   = valid_reg;
   assign local_extended_group_clock_out = local_extended_group_clock_reg;
   assign multiblock_end_marker_out      = mbend_reg;
   assign extended_group_end_flag_out    = embend_reg;
   assign format_bad_out                 = bad_reg;

   // =====================================================================
   // assertions
   // =====================================================================
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!nrst_in);

   a_header_complement: assert property (tx_valid_out |-> tx_block_out[0] != tx_block_out[1])
      else $error("header pair not complementary");
   a_block_wrap: assert property (blk_reg == BLK_LAST && !sr_edge |=> blk_reg == 5'h0)
      else $error("multiblock not 32 blocks");
   a_sysref_phase: assert property (sr_edge |=> blk_reg == 5'h0 && mb_reg == '0 ##1 local_extended_group_clock_reg)
      else $error("sysref did not reset group phase");
   a_end_zeros: assert property (tx_valid_out && oblk_reg >= 5'(jlf_pkg::END_FIRST)
                                 && oblk_reg < 5'(jlf_pkg::END_LAST) |-> tx_block_out[1:0] == jlf_pkg::HDR_ZERO)
      else $error("end marker zeros missing");
   a_end_one: assert property (tx_valid_out && oblk_reg == 5'(jlf_pkg::END_LAST)
                               |-> tx_block_out[1:0] == jlf_pkg::HDR_ONE)
      else $error("end marker one missing");
   a_extended_group_end_flag_bit: assert property (tx_valid_out && oblk_reg == 5'(jlf_pkg::EXTENDED_GROUP_END_FLAG_POS)
                                 |-> (tx_block_out[1:0] == jlf_pkg::HDR_ONE) == (omb_reg == MB_LAST))
      else $error("extended group end bit wrong");
   a_cmd_zero: assert property (tx_valid_out && omode_reg == jlf_pkg::MODE_CRC
                                && oblk_reg inside {5'h10, 5'h11, 5'h12, 5'h14, 5'h18, 5'h19, 5'h1a}
                                |-> tx_block_out[1:0] == jlf_pkg::HDR_ZERO)
      else $error("command position not zero");
   a_first_parity: assert property (first_mb_reg |-> parity_reg == jlf_pkg::PARITY_RST)
      else $error("first multiblock parity not zero");
   a_parity_clear: assert property (blk_reg == BLK_LAST |=> acc_reg == jlf_pkg::PARITY_RST)
      else $error("parity accumulator not cleared");
   a_parity_hold: assert property (active_reg && blk_reg != BLK_LAST && $past(active_reg)
                                   |=> $stable(parity_reg))
      else $error("parity changed mid multiblock");
   a_crc_width: assert property (mode_reg == jlf_pkg::MODE_CRC |-> acc_reg[25:12] == 14'h0)
      else $error("crc state exceeds twelve bits");

   c_group_tick:  cover property (local_extended_group_clock_reg ##[1:300] local_extended_group_clock_reg);
   c_fec_end:     cover property (tx_valid_out && omode_reg == jlf_pkg::MODE_FEC && mbend_reg);
   c_realign:     cover property (tx_valid_out ##1 sr_edge ##1 !active_reg);
   c_second_mb:   cover property (active_reg && !first_mb_reg && parity_reg != jlf_pkg::PARITY_RST);

endmodule // jlf_framer

/* jlf_rx_model.sv */
// receiver model: checks header pairs, sync stream layout and carried parity.
// assumes one block per mclk_in, block 0 first after valid_in rises.
`timescale 1ns/1ps

module jlf_rx_model #(
   parameter int EMB_LEN = 1
) (
   // clock, reset, stream format
   input  wire logic        mclk_in,
   input  wire logic        nrst_in,
   input  wire logic [1:0]  format_in,
   // received blocks
   input  wire logic [65:0] block_in,
   input  wire logic        valid_in,
   // tallies
   output int               bad_out,
   output int               chk_out
);
   logic [31:0] strm, exp_s;
   logic [25:0] par, prev;
   logic        fb, fec;
   int          idx, mbc, seen;

   task automatic chk(input logic ok, input string what);
      chk_out++;
      if (ok !== 1'b1) begin
         bad_out++;
         $display("BAD t=%0t rx %s", $time, what);
      end
   endtask

   // ==========================================================
   // falling edge sampling: registered outputs have settled
   initial begin
      bad_out = 0;
      chk_out = 0;
   end

   always @(negedge mclk_in) begin
      if (nrst_in !== 1'b1 || valid_in !== 1'b1) begin
         // idle: next block is block 0, nothing carried yet
         idx = 0;
         mbc = 0;
         seen = 0;
         par = '0;
         prev = '0;
         fec = (format_in == 2'h2);
      end else begin
         chk(block_in[0] ^ block_in[1], "header pair");
         strm[idx] = (block_in[1:0] == 2'h2);
         // serial divider, octet 0 msb first; mask is the 12-bit poly less x^12
         for (int n = 0; n < 64; n++) begin
            fb = block_in[2 + 8 * (n / 8) + 7 - n % 8] ^ (fec ? par[25] : par[11]);
            par = {par[24:0], 1'b0} & (fec ? 26'h3ffffff : 26'h0000fff);
            if (fb)
               par = par ^ (fec ? jlf_pkg::FEC_POLY : 26'h000030f);
         end
         idx++;
         if (idx == 32) begin
            exp_s = 32'h80000000;
            for (int i = 0; i < 26; i++) begin
               if (fec)
                  exp_s[i < 22 ? i : i + 1] = prev[25 - i];
               else if (i < 12)
                  exp_s[i + i / 3] = prev[11 - i];
            end
            if (!fec)
               exp_s = exp_s | 32'h00a88888;
            exp_s[22] = strm[22];
            chk(strm === exp_s, "stream layout or parity");
            // fec tolerates a stray end marker, only crc forbids it
            for (int i = 0; i < 27; i++)
               if (!fec) chk(strm[i +: 5] !== 5'h10, "early end marker");
            if (strm[22]) begin
               chk(seen == 0 || mbc == EMB_LEN - 1, "group end spacing");
               seen = 1;
               mbc = 0;
            end else begin
               mbc++;
               chk(mbc < EMB_LEN, "group end missing");
            end
            prev = par;
            par = '0;
            idx = 0;
         end
      end
   end
endmodule // jlf_rx_model

/* tb_jlf_framer.sv */
// testbench: random payload in every format, sysref restart mid-link,
// block contents and pulse spacing checked every cycle.
// assumes the framer, its package and the receiver model are compiled.
`timescale 1ns/1ps

module tb_jlf_framer;
   localparam int EMB = 2;
   logic        mclk_in, nrst_in, link_en_in, sysref_in;
   logic [1:0]  sync_header_format_select_in;
   logic [63:0] payload_in, pay;
   logic [65:0] tx_block_out, exp_blk;
   logic        tx_valid_out, local_extended_group_clock_out;
   logic        multiblock_end_marker_out, extended_group_end_flag_out, format_bad_out;
   logic [63:0] pay_q [$];
   logic [57:0] scr;
   logic [2:0]  pls;
   int          seed, err_count, check_count, rx_bad, rx_chk, b;
   int          per [3], gap [3];
   bit          seen [3];
   bit          hold, drop, tick;

   jlf_framer #(.EMB_LEN(EMB)) u_jlf_framer (.mclk_in(mclk_in), .nrst_in(nrst_in), .link_en_in(link_en_in),
      .sync_header_format_select_in(sync_header_format_select_in), .sysref_in(sysref_in),
      .payload_in(payload_in), .tx_block_out(tx_block_out), .tx_valid_out(tx_valid_out),
      .local_extended_group_clock_out(local_extended_group_clock_out),
      .multiblock_end_marker_out(multiblock_end_marker_out),
      .extended_group_end_flag_out(extended_group_end_flag_out), .format_bad_out(format_bad_out));
   jlf_rx_model #(.EMB_LEN(EMB)) u_jlf_rx_model (.mclk_in(mclk_in), .nrst_in(nrst_in),
      .format_in(sync_header_format_select_in), .block_in(tx_block_out), .valid_in(tx_valid_out),
      .bad_out(rx_bad), .chk_out(rx_chk));

   // ==========================================================
   // tasks
   task automatic cmp(input logic [65:0] got, input logic [65:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic test_done;
      err_count = err_count + rx_bad;
      check_count = check_count + rx_chk;
      $display("checks %0d mismatches %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic wait_valid(input logic lvl);
      for (int n = 0; n < 80; n++) begin
         @(negedge mclk_in);
         if (tx_valid_out === lvl)
            return;
      end
      err_count++;
      $display("BAD t=%0t tx valid stuck, wanted %b", $time, lvl);
      test_done();
   endtask

   // one link session; optional sysref hit partway in
   task automatic run_mode(input logic [1:0] fmt, input int nmb, input bit hit);
      @(negedge mclk_in);
      sync_header_format_select_in = fmt;
      link_en_in = 1'b1;
      wait_valid(1'b1);
      if (hit) begin
         repeat (3 + $unsigned($random(seed)) % 40) @(negedge mclk_in);
         sysref_in = 1'b1; // single pulse, no continuous rate to keep
         hold = 1;
         drop = 0;
         tick = 0;
         repeat (3) @(negedge mclk_in);
         sysref_in = 1'b0;
         repeat (9) @(negedge mclk_in);
         hold = 0;
         cmp(66'({drop, tick}), 66'h3, "sysref restart");
         wait_valid(1'b1);
      end
      repeat (32 * nmb) @(negedge mclk_in);
      cmp(66'(format_bad_out), 66'(fmt != 2'h0 && fmt != 2'h2), "format flag");
      link_en_in = 1'b0;
      wait_valid(1'b0);
      $display("test format %0d sysref %0d done", fmt, hit);
   endtask

   // ==========================================================
   // clock, payload driver
   initial begin
      mclk_in = 1'b0;
      forever #10 mclk_in = ~mclk_in;
   end

   always @(negedge mclk_in) begin
      payload_in = {$random(seed), $random(seed)};
      pay_q.push_back(payload_in);
   end

   // ==========================================================
   // monitor: oldest payload note against the block that appears
   always @(posedge mclk_in) begin
      #5;
      exp_blk = 66'h0;
      if (pay_q.size() > 0)
         pay = pay_q.pop_front();
      if (tx_valid_out !== 1'b1) begin
         scr = jlf_pkg::SCR_SEED;
         cmp(tx_block_out, 66'h0, "idle block");
      end else begin
         exp_blk[1:0] = tx_block_out[1:0]; // header pair judged by the receiver
         for (int n = 0; n < 64; n++) begin
            b = 8 * (n / 8) + 7 - n % 8;
            exp_blk[2 + b] = pay[b] ^ scr[38] ^ scr[57];
            scr = {scr[56:0], exp_blk[2 + b]};
         end
         cmp(tx_block_out, exp_blk, "scrambled block");
      end
      // pulse spacing; phase jumps at sysref, so skip that window
      pls = {extended_group_end_flag_out, multiblock_end_marker_out, local_extended_group_clock_out};
      for (int i = 0; i < 3; i++) begin
         gap[i]++;
         if (hold) seen[i] = 1'b0; // phase jump pending, restart spacing
         if (pls[i] === 1'b1) begin
            if (seen[i] && !hold) cmp(66'(gap[i]), 66'(per[i]), "pulse spacing");
            seen[i] = !hold;
            gap[i] = 0;
         end
      end
      drop = drop | (tx_valid_out === 1'b0);
      tick = tick | (pls[0] === 1'b1);
   end

   // ==========================================================
   // main sequence
   initial begin
      seed = 75620;
      err_count = 0;
      check_count = 0;
      per = '{32 * EMB, 32, 32 * EMB};
      gap = '{0, 0, 0};
      nrst_in = 1'b0;
      link_en_in = 1'b0;
      sysref_in = 1'b0;
      sync_header_format_select_in = 2'h0;
      payload_in = 64'h0;
      repeat (4) @(negedge mclk_in);
      nrst_in = 1'b1;
      run_mode(2'h0, 4, 0);
      run_mode(2'h0, 4, 1);
      run_mode(2'h2, 4, 0);
      run_mode(2'h2, 3, 1);
      run_mode(2'h1, 3, 0);
      run_mode(2'h3, 3, 0);
      test_done();
   end
endmodule // tb_jlf_framer
